// ==== rtl/pgt_pkg.sv ====
// Purpose: Constants and types for the power-good tree mask bank
// Assumes: 8-bit register port driven by the serial control engine
// Notes:   Mask bit 1 drops a source, 0 keeps it
package pgt_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_OUTPUT_B_PIN_RAIL_MASK  = 8'h00a9;
  localparam logic [7:0] ADDR_OUTPUT_C_MAIN_RAIL_MASK = 8'h00aa;
  localparam logic [7:0] ADDR_OUTPUT_C_PIN_RAIL_MASK  = 8'h00ab;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_OUTPUT_B_PIN_RAIL_MASK  = 8'h002f;
  localparam logic [7:0] RST_OUTPUT_C_MAIN_RAIL_MASK = 8'h0000;
  localparam logic [7:0] RST_OUTPUT_C_PIN_RAIL_MASK  = 8'h0000;
  localparam logic [7:0] RDATA_UNMAPPED              = 8'h0000;

  // ==========================================================
  // Field positions, main rail group
  localparam int MAIN_AUX_REGULATOR_TWO = 7;
  localparam int MAIN_SWITCH_A          = 6;
  localparam int MAIN_STEPDOWN_RAIL_SIX = 5;
  localparam int MAIN_STEPDOWN_RAIL_ONE = 0;

  // Field positions, pin rail group
  localparam int PIN_CONTROL_PIN_FIVE      = 7;
  localparam int PIN_CONTROL_PIN_FOUR      = 6;
  localparam int PIN_CONTROL_PIN_TWO       = 5;
  localparam int PIN_CONTROL_PIN_ONE       = 4;
  localparam int PIN_TERMINATION_REGULATOR = 3;
  localparam int PIN_SWITCH_B_SECOND       = 2;
  localparam int PIN_SWITCH_B_FIRST        = 1;
  localparam int PIN_AUX_REGULATOR_THREE   = 0;

  // Control pin sync depth
  localparam int SYNC_STAGES = 3;
  localparam int NUM_CTRL_PINS = 4;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [7:0] main_rails;
    logic [7:0] pin_rails;
  } pgt_src_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } pgt_req_t;

endpackage

// ==== rtl/pgt_mask_bank.sv ====
// Purpose: Mask registers and power-good trees for outputs b and c
// Assumes: Rail flags are on i_core_clk; control pins are async pins
// Notes:   Output b main rail mask lives outside and comes in as a port
`timescale 1ns/1ps

module pgt_mask_bank (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_reset_n,
  // Register port
  input  wire pgt_pkg::pgt_req_t i_req,
  output logic [7:0]            o_reg_rdata,
  output logic                  o_reg_rvalid,
  // Sources and external mask
  input  wire pgt_pkg::pgt_src_t i_src_good,
  input  wire logic [7:0]       i_output_b_main_mask,
  // Power-good outputs
  output logic                  o_output_b_power_good,
  output logic                  o_output_c_power_good
);

  // ==========================================================
  // Mask registers
  logic [7:0] output_b_pin_rail_mask_r;
  logic [7:0] output_c_main_rail_mask_r;
  logic [7:0] output_c_pin_rail_mask_r;

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      output_b_pin_rail_mask_r  <= pgt_pkg::RST_OUTPUT_B_PIN_RAIL_MASK;
      output_c_main_rail_mask_r <= pgt_pkg::RST_OUTPUT_C_MAIN_RAIL_MASK;
      output_c_pin_rail_mask_r  <= pgt_pkg::RST_OUTPUT_C_PIN_RAIL_MASK;
    end
    else if (i_req.wr)
    begin
      if (i_req.addr == pgt_pkg::ADDR_OUTPUT_B_PIN_RAIL_MASK)
        output_b_pin_rail_mask_r <= i_req.wdata;
      else if (i_req.addr == pgt_pkg::ADDR_OUTPUT_C_MAIN_RAIL_MASK)
        output_c_main_rail_mask_r <= i_req.wdata;
      else if (i_req.addr == pgt_pkg::ADDR_OUTPUT_C_PIN_RAIL_MASK)
        output_c_pin_rail_mask_r <= i_req.wdata;
    end
  end

  // ==========================================================
  // Read port
  logic [7:0] rdata_nxt;

  always_comb
  begin
    if (i_req.addr == pgt_pkg::ADDR_OUTPUT_B_PIN_RAIL_MASK)
      rdata_nxt = output_b_pin_rail_mask_r;
    else if (i_req.addr == pgt_pkg::ADDR_OUTPUT_C_MAIN_RAIL_MASK)
      rdata_nxt = output_c_main_rail_mask_r;
    else if (i_req.addr == pgt_pkg::ADDR_OUTPUT_C_PIN_RAIL_MASK)
      rdata_nxt = output_c_pin_rail_mask_r;
    else
      rdata_nxt = pgt_pkg::RDATA_UNMAPPED;
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_reg_rdata  <= pgt_pkg::RDATA_UNMAPPED;
      o_reg_rvalid <= 1'b0;
    end
    else
    begin
      o_reg_rvalid <= i_req.rd;
      if (i_req.rd)
        o_reg_rdata <= rdata_nxt;
    end
  end

  // ==========================================================
  // Control pin synchronisers, change taken when stages 2 and 3 agree
  logic [3:0] pin_raw;
  logic [3:0] pin_filt_r;

  assign pin_raw = {i_src_good.pin_rails[pgt_pkg::PIN_CONTROL_PIN_FIVE],
                    i_src_good.pin_rails[pgt_pkg::PIN_CONTROL_PIN_FOUR],
                    i_src_good.pin_rails[pgt_pkg::PIN_CONTROL_PIN_TWO],
                    i_src_good.pin_rails[pgt_pkg::PIN_CONTROL_PIN_ONE]};

  genvar g;
  generate
    for (g = 0; g < pgt_pkg::NUM_CTRL_PINS; g++)
    begin : g_pin_sync
      logic [pgt_pkg::SYNC_STAGES-1:0] sync_r;

      always_ff @(posedge i_core_clk or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          sync_r        <= '0;
          pin_filt_r[g] <= 1'b0;
        end
        else
        begin
          sync_r <= {sync_r[1:0], pin_raw[g]};
          if (sync_r[1] == sync_r[2])
            pin_filt_r[g] <= sync_r[2];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Power-good trees
  logic [7:0] pin_group;

  assign pin_group = {pin_filt_r,
                      i_src_good.pin_rails[pgt_pkg::PIN_TERMINATION_REGULATOR:
                                           pgt_pkg::PIN_AUX_REGULATOR_THREE]};

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_output_b_power_good <= 1'b0;
      o_output_c_power_good <= 1'b0;
    end
    else
    begin
      o_output_b_power_good <=
        &(i_src_good.main_rails | i_output_b_main_mask) &
        &(pin_group | output_b_pin_rail_mask_r);
      o_output_c_power_good <=
        &(i_src_good.main_rails | output_c_main_rail_mask_r) &
        &(pin_group | output_c_pin_rail_mask_r);
    end
  end

endmodule

// ==== sim/pgt_sys_model.sv ====
// Purpose: Rail and pin flag source
// Assumes: High flag means good
// Notes:   Bench picks failing flags
`timescale 1ns/1ps
module pgt_sys_model (
  input  wire logic        i_core_clk,
  input  wire logic [15:0] i_fail,
  output pgt_pkg::pgt_src_t o_src
);
  always_ff @(posedge i_core_clk)
    o_src <= ~i_fail;
endmodule

// ==== sim/pgt_mask_bank_asserts.sv ====
// Purpose: Port checks of the mask bank
// Assumes: One clock domain
// Notes:   Bound to the bank
`timescale 1ns/1ps
module pgt_mask_bank_asserts (
  input wire logic              i_core_clk,
  input wire logic              i_reset_n,
  input wire pgt_pkg::pgt_req_t i_req,
  input wire logic [7:0]        o_reg_rdata,
  input wire logic              o_reg_rvalid,
  input wire pgt_pkg::pgt_src_t i_src_good,
  input wire logic [7:0]        i_output_b_main_mask,
  input wire logic              o_output_b_power_good,
  input wire logic              o_output_c_power_good
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);
  chk_write_read: assert property (i_req.wr ##1 i_req.rd &&
    i_req.addr == $past(i_req.addr) && i_req.addr inside {8'h00a9,
    8'h00aa, 8'h00ab} |=> o_reg_rdata == $past(i_req.wdata, 2))
    else $error("readback");
  chk_unmapped_zero: assert property (i_req.rd && !(i_req.addr inside
    {8'h00a9, 8'h00aa, 8'h00ab}) |=> o_reg_rdata == 8'h0000)
    else $error("unmapped");
  chk_rdata_hold: assert property (!i_req.rd |=> $stable(o_reg_rdata))
    else $error("rdata moved");
  chk_read_valid: assert property (i_req.rd |=> o_reg_rvalid)
    else $error("rvalid");
  chk_valid_pulse: assert property (!i_req.rd |=> !o_reg_rvalid)
    else $error("stray rvalid");
  chk_b_rail_drop: assert property ((!i_src_good.main_rails[7] &&
    !i_output_b_main_mask[7]) [*3] |=> !o_output_b_power_good)
    else $error("b tree");
  chk_all_good: assert property ((&i_src_good) [*8] |=>
    o_output_b_power_good && o_output_c_power_good) else $error("trees");
endmodule
bind pgt_mask_bank pgt_mask_bank_asserts chk_u (.*);

// ==== sim/tb.sv ====
// Purpose: Register and tree tests
// Assumes: Pin path settles in 10 cycles
// Notes:   Flags fail via the model
`timescale 1ns/1ps
`define CHK(g, e) \
  begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic              clk, rst_n, rv, pb, pc;
  logic [7:0]        rdata, bm;
  logic [15:0]       fail;
  pgt_pkg::pgt_req_t req;
  pgt_pkg::pgt_src_t src;
  int                err_count, cmp_count;
  pgt_sys_model sys_u (.i_core_clk(clk), .i_fail(fail), .o_src(src));
  pgt_mask_bank dut_u (.i_core_clk(clk), .i_reset_n(rst_n), .i_req(req),
    .o_reg_rdata(rdata), .o_reg_rvalid(rv), .i_src_good(src),
    .i_output_b_main_mask(bm), .o_output_b_power_good(pb),
    .o_output_c_power_good(pc));
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    req <= '{a, w, !w, d};
    @(posedge clk);
    req <= '{a, 1'b0, 1'b0, d};
    #1;
    if (!w)
    begin
      `CHK(rv, 1'b1)
      `CHK(rdata, d)
    end
  endtask
  task automatic wrd(input logic [7:0] a, d);
    @(posedge clk);
    req <= '{a, 1'b1, 1'b0, d};
    @(posedge clk);
    req <= '{a, 1'b0, 1'b1, d};
    @(posedge clk);
    req <= '{a, 1'b0, 1'b0, d};
    #1;
    `CHK(rv, 1'b1)
    `CHK(rdata, d)
  endtask
  task automatic pg(input logic [15:0] f, input logic [7:0] m,
                    input logic [1:0] e);
    @(posedge clk);
    fail <= f;
    bm <= m;
    repeat (10) @(posedge clk);
    #1;
    `CHK({pb, pc}, e)
  endtask
  task automatic tally_and_finish;
    $display("compares=%0d errors=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    rst_n = 0;
    req = '0;
    fail = '0;
    bm = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    acc(0, 8'h00a9, 8'h002f);
    acc(0, 8'h00aa, 8'h0000);
    acc(0, 8'h00ab, 8'h0000);
    acc(1, 8'h00ac, 8'h0055);
    acc(0, 8'h00ac, 8'h0000);
    pg(16'h0000, 8'h0000, 2'h3);
    pg(16'h0020, 8'h0000, 2'h2);
    pg(16'h0010, 8'h0000, 2'h0);
    pg(16'h0008, 8'h0000, 2'h2);
    pg(16'h8000, 8'h0080, 2'h2);
    pg(16'h8000, 8'h0000, 2'h0);
    acc(1, 8'h00aa, 8'h00ff);
    acc(1, 8'h00ab, 8'h00ff);
    acc(0, 8'h00aa, 8'h00ff);
    acc(0, 8'h00ab, 8'h00ff);
    pg(16'hffff, 8'h00ff, 2'h1);
    acc(1, 8'h00a9, 8'h0000);
    pg(16'h0001, 8'h0000, 2'h1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    acc(0, 8'h00a9, 8'h002f);
    acc(0, 8'h00ab, 8'h0000);
    wrd(8'h00aa, 8'h0042);
    tally_and_finish();
  end
endmodule
